// ### logic/sxt_pkg.sv
// sxt_pkg: constants for the storage expansion translator
// assumes a byte-wide processor storage path with 18-bit virtual and real addresses
package sxt_pkg;
   localparam int unsigned ADDR_W = 18;
   localparam int unsigned BLK_W = 6;
   localparam int unsigned LVL_W = 3;
   localparam int unsigned OFS_W = 12;
   localparam int unsigned TTA_IDX_W = LVL_W + BLK_W;
   localparam int unsigned TTA_DEPTH = 512;
   // table window in processor storage space, one byte per entry
   localparam logic [15:0] TTA_BASE = 16'hfc00;
   localparam logic [15:0] TTA_TOP = 16'hfdff;
   // translate entry layout: protect bit and real block number
   localparam int unsigned ENT_PROT = 7;
   localparam logic [7:0] ENT_BLK_MASK = 8'h3f;
   // register port offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_MASK = 8'h08;
   localparam logic [7:0] REG_IRQ = 8'h0c;
   // control register bits (write-only actions except enable)
   localparam int unsigned CTL_ENABLE = 0;
   localparam int unsigned CTL_INHIBIT = 1;
   localparam int unsigned CTL_RST_INH = 2;
   localparam int unsigned CTL_VIO_RST = 3;
   localparam int unsigned CTL_DISABLE = 4;
   // status register bits
   localparam int unsigned ST_ENABLE = 0;
   localparam int unsigned ST_INHIBIT = 1;
   localparam int unsigned ST_TTA_PAR = 2;
   localparam int unsigned ST_PROT_VIO = 3;
   localparam int unsigned ST_MPC_LO = 4;
   localparam int unsigned ST_MPC_HI = 5;
   localparam int unsigned ST_BLK16K = 6;
   localparam logic [7:0] ST_RESET = 8'h02;
   localparam logic [7:0] EVT_BITS = 8'h3c;
   localparam int unsigned IRQ_LEVEL0 = 0;
endpackage : sxt_pkg

// ### logic/sxt_translator.sv
// sxt_translator: storage expansion unit between the processor and main storage
// assumes one clock, synchronous inputs, main storage answers reads in the next cycle
// How it works
// - after reset the status shows inhibit set and every other bit clear
// - status holds memory parity check bits and a 16K block installed bit
// - every table entry is a readable, writable byte returning the last value
// - a table parity error on read raises a level 0 interrupt request
// - table parity flag stays set until software writes one to clear it
// - writing the control inhibit bit sets the status inhibit indication
// - writing the control enable bit sets the status enable indication
// - writing the control reset-inhibit bit clears the inhibit indication
// - level 0 entries accept any block value including 10 hex and upward
// - a storage error sets a memory parity check bit and level 0 request
// - each of eight levels has its own entries selecting the real block
// - a virtual read returns data from the real block the entry chooses
// - writes to a block whose entry has protect set are aborted
// - an aborted write sets the protect violation status bit
// - a protect violation raises a level 0 request
// - writing the violation reset bit clears the protect violation bit
// - the control register can disable the feature, stopping translation
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module sxt_translator (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // processor storage request
   input wire logic [sxt_pkg::ADDR_W-1:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [sxt_pkg::LVL_W-1:0] cpu_level,
   output logic [7:0] cpu_rdata,
   // main storage side
   output logic [sxt_pkg::ADDR_W-1:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic mem_wr,
   output logic mem_rd,
   input wire logic [7:0] mem_rdata,
   input wire logic [1:0] mem_par_err,
   input wire logic blk16k_present,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // interrupt
   output logic io_irq
);
   import sxt_pkg::*;

   // table entry plus its parity bit; parity kept odd
   logic [8:0] translate_table_array [TTA_DEPTH];
   logic [7:0] status_q;
   // one flop per status field, so each bit has a single driving process
   logic en_q;
   logic inh_q;
   logic tpar_q;
   logic vio_q;
   logic [1:0] mpc_q;
   logic blk_q;
   logic [7:0] mask_q;
   logic [7:0] io_interrupt_request_reg;
   logic [7:0] cpu_rdata_q;
   logic [7:0] reg_rdata_q;
   logic rd_tta_q;
   logic rd_mem_q;
   logic [8:0] tta_rd_q;
   logic tta_hit;
   logic xlate_on;
   logic [TTA_IDX_W-1:0] tta_idx;
   logic [TTA_IDX_W-1:0] map_idx;
   logic [8:0] map_ent;
   logic prot_hit;
   logic ctl_wr;
   logic stat_wr;
   logic tta_par_evt;
   logic vio_evt;
   logic mpc_evt;

   function automatic logic odd_par(input logic [7:0] v);
      return ~(^v);
   endfunction : odd_par

   assign tta_hit = (cpu_addr[15:0] >= TTA_BASE) && (cpu_addr[15:0] <= TTA_TOP)
                    && (cpu_addr[ADDR_W-1:16] == '0);
   assign tta_idx = cpu_addr[TTA_IDX_W-1:0];
   // entry per level and 4K block
   assign map_idx = {cpu_level, cpu_addr[ADDR_W-1:OFS_W]};
   assign map_ent = translate_table_array[map_idx];
   // both enable and inhibit gate translation
   assign xlate_on = status_q[ST_ENABLE] & ~status_q[ST_INHIBIT];
   assign prot_hit = xlate_on & map_ent[ENT_PROT] & cpu_wr & ~tta_hit;
   assign ctl_wr = reg_wr && (reg_addr == REG_CTRL);
   assign stat_wr = reg_wr && (reg_addr == REG_STAT);
   assign tta_par_evt = rd_tta_q && (odd_par(tta_rd_q[7:0]) != tta_rd_q[8]);
   assign vio_evt = prot_hit;
   assign mpc_evt = rd_mem_q && (mem_par_err != 2'h0);

   // storage path: translated address, aborted protected writes
   always_comb begin
      mem_addr = cpu_addr;
      if (xlate_on) begin
         mem_addr = {map_ent[BLK_W-1:0] & ENT_BLK_MASK[BLK_W-1:0], cpu_addr[OFS_W-1:0]};
      end
      mem_wdata = cpu_wdata;
      mem_wr = cpu_wr & ~tta_hit & ~prot_hit;
      mem_rd = cpu_rd & ~tta_hit;
   end

   // table array writes, any byte value accepted
   always_ff @(posedge ref_clk) begin
      if (cpu_wr && tta_hit) begin
         translate_table_array[tta_idx] <= {odd_par(cpu_wdata), cpu_wdata};
      end
   end

   // read return, one cycle later
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_tta_q <= 1'b0;
         rd_mem_q <= 1'b0;
         tta_rd_q <= 9'h000;
      end else begin
         rd_tta_q <= cpu_rd & tta_hit;
         rd_mem_q <= cpu_rd & ~tta_hit;
         tta_rd_q <= translate_table_array[tta_idx];
      end
   end

   always_comb begin
      cpu_rdata = rd_tta_q ? tta_rd_q[7:0] : (rd_mem_q ? mem_rdata : cpu_rdata_q);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cpu_rdata_q <= 8'h00;
      end else if (rd_tta_q || rd_mem_q) begin
         cpu_rdata_q <= cpu_rdata;
      end
   end

   assign status_q = {1'b0, blk_q, mpc_q, vio_q, tpar_q, inh_q, en_q};

   // enable and inhibit indications
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         en_q <= ST_RESET[ST_ENABLE];
         inh_q <= ST_RESET[ST_INHIBIT];
      end else if (ctl_wr) begin
         if (reg_wdata[CTL_DISABLE]) begin
            en_q <= 1'b0;
         end else if (reg_wdata[CTL_ENABLE]) begin
            en_q <= 1'b1;
         end
         if (reg_wdata[CTL_INHIBIT]) begin
            inh_q <= 1'b1;
         end else if (reg_wdata[CTL_RST_INH]) begin
            inh_q <= 1'b0;
         end
      end
   end

   // sticky event bits: set wins over a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tpar_q <= ST_RESET[ST_TTA_PAR];
      end else if (tta_par_evt) begin
         tpar_q <= 1'b1;
      end else if (stat_wr && reg_wdata[ST_TTA_PAR]) begin
         tpar_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         vio_q <= ST_RESET[ST_PROT_VIO];
      end else if (vio_evt) begin
         vio_q <= 1'b1;
      end else if ((ctl_wr && reg_wdata[CTL_VIO_RST]) || (stat_wr && reg_wdata[ST_PROT_VIO])) begin
         vio_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mpc_q <= ST_RESET[ST_MPC_HI:ST_MPC_LO];
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (rd_mem_q && mem_par_err[i]) begin
               mpc_q[i] <= 1'b1;
            end else if (stat_wr && reg_wdata[ST_MPC_LO + i]) begin
               mpc_q[i] <= 1'b0;
            end
         end
      end
   end

   // installed indication is sampled, not sticky
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         blk_q <= ST_RESET[ST_BLK16K];
      end else begin
         blk_q <= blk16k_present;
      end
   end

   // level 0 request stays until written one to clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         io_interrupt_request_reg <= 8'h00;
      end else if (tta_par_evt || vio_evt || mpc_evt) begin
         io_interrupt_request_reg[IRQ_LEVEL0] <= 1'b1;
      end else if (reg_wr && (reg_addr == REG_IRQ) && reg_wdata[IRQ_LEVEL0]) begin
         io_interrupt_request_reg[IRQ_LEVEL0] <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mask_q <= 8'h00;
      end else if (reg_wr && (reg_addr == REG_MASK)) begin
         mask_q <= reg_wdata & EVT_BITS;
      end
   end

   // unmasked events and the level 0 request both drive the line
   assign io_irq = |(status_q & mask_q & EVT_BITS) | io_interrupt_request_reg[IRQ_LEVEL0];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL: reg_rdata_q <= {7'h00, status_q[ST_ENABLE]};
            REG_STAT: reg_rdata_q <= status_q;
            REG_MASK: reg_rdata_q <= mask_q;
            REG_IRQ: reg_rdata_q <= io_interrupt_request_reg;
            default: reg_rdata_q <= 8'h00;
         endcase
      end else begin
         reg_rdata_q <= 8'h00;
      end
   end

   assign reg_rdata = reg_rdata_q;
endmodule : sxt_translator
`default_nettype wire

// ### sim/sxt_mem_model.sv
// sxt_mem_model: main storage behind the translator
// assumes reads answer one cycle after mem_rd
`timescale 1ns/10ps
`default_nettype none
module sxt_mem_model
   import sxt_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // storage request
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_wr,
   input wire logic mem_rd,
   output logic [7:0] mem_rdata,
   output logic [1:0] mem_par_err,
   // error injection
   input wire logic bad_par
);
   logic [7:0] mem [0:(1<<ADDR_W)-1];
   initial begin
      mem_rdata = 8'h00;
      mem_par_err = 2'b00;
   end
   // data does not hold after the read cycle: show the inverse
   always @(posedge ref_clk) begin
      mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
      mem_par_err <= {1'b0, mem_rd & bad_par};
      if (mem_wr) begin
         mem[mem_addr] <= mem_wdata;
      end
   end
endmodule : sxt_mem_model
`default_nettype wire

// ### sim/sxt_translator_chk.sv
// sxt_chk: port assertions for the translator
// assumes bind onto sxt_translator, one clock
`timescale 1ns/10ps
`default_nettype none
module sxt_chk
   import sxt_pkg::*;
(
   // watched ports
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic [1:0] mem_par_err,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic io_irq
);
   // table window, never forwarded to storage
   wire tw = cpu_addr[17:9] == 9'h07e;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // reset itself is the cause here, so no disable
   property p_rst;
      disable iff (1'b0) rst ##1 (!rst && reg_rd && reg_addr == REG_STAT)
         |=> reg_rdata == ST_RESET;
   endproperty
   a_rst: assert property (p_rst) else $error("bad status after reset");
   property p_twr; cpu_wr && tw |-> !mem_wr; endproperty
   a_twr: assert property (p_twr) else $error("table write hit storage");
   property p_trd; cpu_rd && tw |-> !mem_rd; endproperty
   a_trd: assert property (p_trd) else $error("table read hit storage");
   property p_ofs; (cpu_rd || cpu_wr) && !tw |-> mem_addr[11:0] == cpu_addr[11:0]; endproperty
   a_ofs: assert property (p_ofs) else $error("block offset changed");
   property p_nwr; !cpu_wr |-> !mem_wr; endproperty
   a_nwr: assert property (p_nwr) else $error("spurious storage write");
   property p_prd; cpu_rd && !tw |-> mem_rd; endproperty
   a_prd: assert property (p_prd) else $error("storage read dropped");
   property p_vio; cpu_wr && !tw && !mem_wr |=> io_irq; endproperty
   a_vio: assert property (p_vio) else $error("no irq on aborted write");
   property p_par; mem_rd ##1 (mem_par_err != 2'b00) |=> io_irq; endproperty
   a_par: assert property (p_par) else $error("no irq on storage error");
   c_vio: cover property (cpu_wr && !tw && !mem_wr);
   c_par: cover property (mem_par_err != 2'b00);
   c_irq: cover property ($fell(io_irq));
endmodule : sxt_chk
bind sxt_translator sxt_chk i_sxt_chk (.*);
`default_nettype wire

// ### sim/tb_sxt_translator.sv
// tb_sxt_translator: directed register and storage tests
// assumes sxt_mem_model as main storage
`timescale 1ns/10ps
`default_nettype none
module tb_sxt_translator;
   import sxt_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] cpu_addr = '0;
   logic [7:0] cpu_wdata = 8'h00;
   logic cpu_wr = 1'b0;
   logic cpu_rd = 1'b0;
   logic [LVL_W-1:0] cpu_level = '0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic blk16k_present = 1'b0;
   logic bad_par = 1'b0;
   logic [7:0] cpu_rdata, mem_wdata, mem_rdata, reg_rdata;
   logic [ADDR_W-1:0] mem_addr;
   logic [1:0] mem_par_err;
   logic mem_wr, mem_rd, io_irq;
   logic [7:0] pat [4] = '{8'hff, 8'h80, 8'h00, 8'h10};
   int error_cnt = 0;
   int cmp_count = 0;
   sxt_translator i_sxt_translator (.*);
   sxt_mem_model i_sxt_mem_model (.*);
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rreg
   // one cpu access; read data is looked at in the cycle it returns, and the translator holds it after
   task automatic cpu(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                      input logic [LVL_W-1:0] l);
      @(posedge ref_clk);
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_level <= l;
      cpu_wr <= w;
      cpu_rd <= !w;
      @(posedge ref_clk);
      cpu_wr <= 1'b0;
      cpu_rd <= 1'b0;
      #1;
   endtask : cpu
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      reg_addr <= REG_STAT;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, ST_RESET);
      wreg(REG_CTRL, 8'h02);
      rreg(REG_STAT, 8'h02);
      wreg(REG_CTRL, 8'h01);
      rreg(REG_STAT, 8'h03);
      wreg(REG_CTRL, 8'h05);
      rreg(REG_STAT, 8'h01);
      rreg(8'h10, 8'h00);
      $display("control test end");
      foreach (pat[i]) begin
         cpu(1'b1, 18'h0fc11, pat[i], 3'h0);
         cpu(1'b0, 18'h0fc11, 8'h00, 3'h0);
         chk(cpu_rdata, pat[i]);
      end
      for (int l = 0; l < 8; l++) begin
         i_sxt_mem_model.mem[{6'(l + 2), 12'hfff}] = 8'(8'h80 >> l);
         cpu(1'b1, ADDR_W'(18'h0fc02 + 64 * l), 8'(l + 2), 3'h0);
      end
      for (int l = 0; l < 8; l++) begin
         cpu(1'b0, 18'h02fff, 8'h00, 3'(l));
         chk(cpu_rdata, 8'(8'h80 >> l));
      end
      $display("table test end");
      cpu(1'b1, 18'h0fc02, 8'h82, 3'h0);
      cpu(1'b1, 18'h02fff, 8'h55, 3'h0);
      rreg(REG_STAT, 8'h09);
      rreg(REG_IRQ, 8'h01);
      chk({7'h00, io_irq}, 8'h01);
      wreg(REG_CTRL, 8'h09);
      rreg(REG_STAT, 8'h01);
      cpu(1'b0, 18'h02fff, 8'h00, 3'h0);
      chk(cpu_rdata, 8'h80);
      wreg(REG_IRQ, 8'h01);
      $display("protect test end");
      bad_par <= 1'b1;
      cpu(1'b0, 18'h02000, 8'h00, 3'h0);
      bad_par <= 1'b0;
      rreg(REG_STAT, 8'h11);
      rreg(REG_IRQ, 8'h01);
      // mask is still clear, so clearing the request must drop the line
      wreg(REG_IRQ, 8'h01);
      chk({7'h00, io_irq}, 8'h00);
      wreg(REG_MASK, 8'h10);
      chk({7'h00, io_irq}, 8'h01);
      wreg(REG_STAT, 8'h10);
      chk({7'h00, io_irq}, 8'h00);
      $display("parity test end");
      wreg(REG_CTRL, 8'h10);
      rreg(REG_STAT, 8'h00);
      cpu(1'b0, 18'h02fff, 8'h00, 3'h3);
      chk(cpu_rdata, 8'h80);
      @(posedge ref_clk);
      blk16k_present <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rreg(REG_STAT, 8'h40);
      $display("disable test end");
      close_out();
   end
   initial begin
      repeat (3000) @(posedge ref_clk);
      error_cnt++;
      close_out();
   end
endmodule : tb_sxt_translator
`default_nettype wire
